/* src/holding_regs.sv */
// Eight byte-wide program-memory holding registers, one write port.
// Assumes writes come from the execution block; read port is for the flash logic.
`timescale 1ns/1ps
`default_nettype none
module holding_regs
	import instr_exec_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  we,
	input  wire logic [HOLD_IDX_W-1:0] wr_idx,
	input  wire logic [7:0]            wr_data,
	input  wire logic [HOLD_IDX_W-1:0] rd_idx,
	output logic      [7:0]            rd_data
);
	logic [7:0] mem_q [HOLD_N];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < HOLD_N; i++) begin
				mem_q[i] <= HOLD_RESET;
			end
		end else if (we) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= HOLD_RESET;
		end else begin
			rd_data <= mem_q[rd_idx];
		end
	end
endmodule
`default_nettype wire

/* src/instr_exec.sv */
// Execution of the table-write and test-zero-skip instructions.
// Assumes the core offers one instruction word per cycle while instr_ready is high,
// answers file_addr with file_data in the same cycle and reports whether the
// already fetched next instruction is two words long.
`timescale 1ns/1ps
`default_nettype none
module instr_exec
	import instr_exec_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  instr_valid,
	input  wire logic [15:0]           instr_word,
	output logic                       instr_ready,
	input  wire logic                  ext_set_en,
	input  wire logic [3:0]            bank_select_reg,
	input  wire logic [ADDR_W-1:0]     fsr2_base,
	output logic      [ADDR_W-1:0]     file_addr,
	input  wire logic [7:0]            file_data,
	input  wire logic                  next_two_word,
	output logic                       discard_fetch,
	output logic                       nop_cycle,
	output logic                       status_we,
	input  wire logic [7:0]            table_latch,
	input  wire logic                  ptr_load,
	input  wire logic [PTR_W-1:0]      ptr_load_val,
	output logic      [PTR_W-1:0]      table_pointer,
	input  wire logic [HOLD_IDX_W-1:0] hold_rd_idx,
	output logic      [7:0]            hold_rd_data
);
	typedef struct packed {
		exec_state_e      state;
		logic [PTR_W-1:0] ptr;
		logic [1:0]       mode;
		logic             skip_two;
		logic             discard;
	} exec_s;

	exec_s s_q;
	exec_s s_d;
	logic  rst_sync1_q;
	logic  rst_sync2_q;
	logic  rst_n;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end
	assign rst_n = rst_sync2_q;

	// Wrapping pointer step, used for increment and decrement
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
			input logic down);
		ptr_step = down ? p - PTR_ONE : p + PTR_ONE;
	endfunction

	// File operand to data address
	function automatic logic [ADDR_W-1:0] file_map(input logic [7:0] f, input logic a,
			input logic ext, input logic [3:0] bank, input logic [ADDR_W-1:0] fsr2);
		if (a) begin
			file_map = {bank, f};
		end else if (ext && f <= INDEXED_MAX) begin
			file_map = ADDR_W'(fsr2 + {4'h0, f});
		end else if (f <= ACCESS_LOW_MAX) begin
			file_map = {ACCESS_LOW_BANK, f};
		end else begin
			file_map = {ACCESS_HIGH_BANK, f};
		end
	endfunction

	logic                  is_tstz;
	logic                  is_twrite;
	logic                  take;
	logic                  hold_we;
	logic [HOLD_IDX_W-1:0] hold_idx;
	logic [PTR_W-1:0]      wr_ptr;

	assign instr_ready = (s_q.state == ST_IDLE);
	assign take = instr_valid && instr_ready;
	assign is_tstz = (instr_word[15:TSTZ_OPC_LSB] == TSTZ_OPC);
	assign is_twrite = (instr_word[15:TWR_OPC_LSB] == TWR_OPC);
	assign file_addr = file_map(instr_word[7:0], instr_word[ACC_BIT], ext_set_en,
		bank_select_reg, fsr2_base);

	assign wr_ptr = (s_q.mode == TW_PRE_INC) ? ptr_step(s_q.ptr, 1'b0) : s_q.ptr;
	assign hold_idx = wr_ptr[HOLD_IDX_W-1:0];
	assign hold_we = (s_q.state == ST_TWRITE);
	assign nop_cycle = (s_q.state == ST_SKIP1) || (s_q.state == ST_SKIP2);
	assign discard_fetch = s_q.discard;
	assign status_we = 1'b0;
	assign table_pointer = s_q.ptr;

	always_comb begin
		s_d = s_q;
		s_d.discard = 1'b0;
		case (s_q.state)
			ST_IDLE: begin
				if (ptr_load) begin
					s_d.ptr = ptr_load_val;
				end
				if (take && is_twrite) begin
					s_d.mode = instr_word[1:0];
					s_d.state = ST_TWRITE;
				end else if (take && is_tstz && file_data == 8'h00) begin
					s_d.discard = 1'b1;
					s_d.skip_two = next_two_word;
					s_d.state = ST_SKIP1;
				end
			end
			ST_TWRITE: begin
				case (s_q.mode)
					TW_POST_INC: s_d.ptr = ptr_step(s_q.ptr, 1'b0);
					TW_POST_DEC: s_d.ptr = ptr_step(s_q.ptr, 1'b1);
					TW_PRE_INC: s_d.ptr = wr_ptr;
					default: s_d.ptr = s_q.ptr;
				endcase
				s_d.state = ST_IDLE;
			end
			ST_SKIP1: begin
				s_d.state = s_q.skip_two ? ST_SKIP2 : ST_IDLE;
			end
			ST_SKIP2: begin
				s_d.skip_two = 1'b0;
				s_d.state = ST_IDLE;
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{state: ST_IDLE, ptr: PTR_RESET, mode: TW_NONE, skip_two: 1'b0,
				discard: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	holding_regs u_hold (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (hold_we),
		.wr_idx  (hold_idx),
		.wr_data (table_latch),
		.rd_idx  (hold_rd_idx),
		.rd_data (hold_rd_data)
	);

	tstz_opcode_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && instr_word[15:9] == 7'h33 && file_data == 8'h00
		|=> s_q.state == ST_SKIP1)
		else $error("zero test not decoded as skip");

	skip_two_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_tstz && file_data == 8'h00 && !next_two_word
		|=> discard_fetch && nop_cycle ##1 instr_ready && !nop_cycle)
		else $error("skip did not take exactly two cycles");

	skip_three_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_tstz && file_data == 8'h00 && next_two_word
		|=> nop_cycle [*2] ##1 instr_ready)
		else $error("skip over two-word instruction not three cycles");

	no_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_tstz && file_data != 8'h00 |=> instr_ready && !discard_fetch)
		else $error("nonzero test skipped");

	flags_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
		!status_we)
		else $error("status flags written");

	access_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_word[8] && !ext_set_en |-> file_addr[11:8] ==
			(instr_word[7:0] <= 8'h5F ? 4'h0 : 4'hF))
		else $error("access bank mapping wrong");

	banked_a: assert property (@(posedge clk) disable iff (!rst_n)
		instr_word[8] |-> file_addr == {bank_select_reg, instr_word[7:0]})
		else $error("banked mapping wrong");

	indexed_a: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5F
		|-> file_addr == ADDR_W'(fsr2_base + {4'h0, instr_word[7:0]}))
		else $error("indexed literal offset mapping wrong");

	post_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold_we && s_q.mode == TW_POST_INC
		|-> hold_idx == s_q.ptr[2:0] ##1 table_pointer == $past(s_q.ptr) + 21'h1)
		else $error("post-increment write wrong");

	pre_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold_we && s_q.mode == TW_PRE_INC
		|-> hold_idx == 3'(s_q.ptr[2:0] + 3'h1) ##1 table_pointer == $past(s_q.ptr) + 21'h1)
		else $error("pre-increment write wrong");

	twrite_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_twrite |=> hold_we && !instr_ready ##1 instr_ready && !hold_we)
		else $error("table write not two cycles");

	ptr_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold_we && s_q.mode == TW_POST_DEC && s_q.ptr == 21'h000000
		|=> table_pointer == 21'h1FFFFF)
		else $error("pointer decrement did not wrap");

	write_index_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold_we && (s_q.mode == TW_NONE || s_q.mode == TW_POST_DEC)
		|-> hold_idx == s_q.ptr[2:0])
		else $error("holding register index wrong");

	skip_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		take && is_tstz |=> !hold_we)
		else $error("zero test wrote a holding register");

	post_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold_we && s_q.mode == TW_POST_DEC
		|=> table_pointer == $past(s_q.ptr) - 21'h1)
		else $error("post-decrement step wrong");
endmodule
`default_nettype wire

/* src/instr_exec_pkg.sv */
// Constants and types for the table-write and test-zero-skip execution block.
// Assumes one clock edge per instruction cycle of the core.
// Operation
// - File value zero discards the fetched instruction; a no-op cycle follows.
// - Skip over a two-word instruction makes three cycles in total.
// - Test-zero-skip never changes any status flag.
// - Access bit clear maps the file operand onto the access bank, except for the indexed literal offset case below.
// - Access bit set takes the bank from the bank select register.
// - Extended set, access bit clear, operand at most 95: indexed literal offset.
// - Post-increment write uses the current pointer, then adds one.
// - Pre-increment adds one to the pointer, then writes at the new value.
// - Pointer bits 2:0 pick one of eight holding registers.
// - Table pointer is a 21-bit byte address; steps wrap within it.
package instr_exec_pkg;
	localparam int PTR_W     = 21;
	localparam int ADDR_W    = 12;
	localparam int HOLD_N    = 8;
	localparam int HOLD_IDX_W = 3;

	localparam logic [6:0]  TSTZ_OPC    = 7'h33;
	localparam int          TSTZ_OPC_LSB = 9;
	localparam int          ACC_BIT     = 8;
	localparam logic [13:0] TWR_OPC     = 14'h0003;
	localparam int          TWR_OPC_LSB = 2;

	localparam logic [1:0] TW_NONE = 2'h0;
	localparam logic [1:0] TW_POST_INC = 2'h1;
	localparam logic [1:0] TW_POST_DEC = 2'h2;
	localparam logic [1:0] TW_PRE_INC = 2'h3;

	localparam logic [7:0]  INDEXED_MAX = 8'h5F;
	localparam logic [7:0]  ACCESS_LOW_MAX = 8'h5F;
	localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
	localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;

	localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
	localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
	localparam logic [7:0]       HOLD_RESET = 8'hFF;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TWRITE,
		ST_SKIP1,
		ST_SKIP2
	} exec_state_e;
endpackage

/* tb/testbench.sv */
// Self-checking bench for the table-write and test-zero-skip execution block.
// Assumes the bench stands in for the core, the file registers and the latch.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import instr_exec_pkg::*;
	logic                  clk, rstn, instr_valid, ext_set_en, next_two_word, ptr_load;
	logic [15:0]           instr_word;
	logic [3:0]            bank_select_reg;
	logic [ADDR_W-1:0]     fsr2_base, file_addr;
	logic [7:0]            file_data, table_latch, hold_rd_data;
	logic [PTR_W-1:0]      ptr_load_val, table_pointer;
	logic [HOLD_IDX_W-1:0] hold_rd_idx;
	logic                  instr_ready, discard_fetch, nop_cycle, status_we;
	int                    mismatches, n_compared;

	instr_exec instr_exec_inst (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg), .fsr2_base(fsr2_base), .file_addr(file_addr),
		.file_data(file_data), .next_two_word(next_two_word), .discard_fetch(discard_fetch),
		.nop_cycle(nop_cycle), .status_we(status_we), .table_latch(table_latch),
		.ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .table_pointer(table_pointer),
		.hold_rd_idx(hold_rd_idx), .hold_rd_data(hold_rd_data));

	task automatic chk(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic issue(input logic [15:0] w, input logic [7:0] fd, input logic two);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		file_data <= fd;
		next_two_word <= two;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic wait_ready;
		for (int i = 0; i < 8 && instr_ready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (instr_ready !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t ready never returned", $time);
			close_out();
		end
	endtask

	task automatic rd_hold(input logic [2:0] idx, input logic [7:0] exp);
		@(posedge clk);
		hold_rd_idx <= idx;
		@(posedge clk);
		#1;
		chk(hold_rd_data, exp);
	endtask

	// One table write: latch, pointer load, instruction, then pointer and holding checks
	task automatic tw(input logic [1:0] mode, input logic [PTR_W-1:0] p,
		input logic [PTR_W-1:0] exp_p, input logic [7:0] lat, input logic [2:0] other);
		@(posedge clk);
		table_latch <= lat;
		ptr_load <= 1'b1;
		ptr_load_val <= p;
		@(posedge clk);
		ptr_load <= 1'b0;
		issue({14'h0003, mode}, 8'h01, 1'b0);
		chk(instr_ready, 1'b0);
		wait_ready;
		chk(table_pointer, exp_p);
		rd_hold((mode == TW_PRE_INC) ? exp_p[2:0] : p[2:0], lat);
		rd_hold(other, 8'hFF);
	endtask

	task automatic sc_twrite;
		tw(TW_POST_INC, 21'h00A356, 21'h00A357, 8'h55, 3'h7);
		tw(TW_PRE_INC, 21'h01389A, 21'h01389B, 8'h34, 3'h2);
		tw(TW_POST_INC, 21'h1FFFFF, 21'h000000, 8'hA5, 3'h0);
		tw(TW_POST_DEC, 21'h000004, 21'h000003, 8'h3C, 3'h5);
		tw(TW_NONE, 21'h000001, 21'h000001, 8'h11, 3'h5);
		tw(TW_POST_DEC, 21'h000000, 21'h1FFFFF, 8'h5A, 3'h2);
	endtask

	task automatic sc_skip;
		issue(16'h6A20, 8'h00, 1'b0);
		chk(discard_fetch, 1'b0);
		for (int k = 0; k < 3; k++) begin
			issue({TSTZ_OPC, 1'b0, 8'h20}, (k == 0) ? 8'h07 : 8'h00, k == 2);
			chk(discard_fetch, k != 0);
			chk(nop_cycle, k != 0);
			chk(instr_ready, k == 0);
			chk(status_we, 1'b0);
			@(posedge clk);
			#1;
			chk(discard_fetch, 1'b0);
			chk(nop_cycle, k == 2);
			chk(instr_ready, k != 2);
			chk(status_we, 1'b0);
			if (k == 2) begin
				@(posedge clk);
				#1;
			end
			chk(instr_ready, 1'b1);
			chk(nop_cycle, 1'b0);
		end
	endtask

	task automatic addr(input logic ext, input logic a, input logic [7:0] f,
		input logic [11:0] exp);
		@(posedge clk);
		ext_set_en <= ext;
		instr_word <= {TSTZ_OPC, a, f};
		#1;
		chk(file_addr, exp);
	endtask

	task automatic sc_addr;
		addr(1'b0, 1'b0, 8'h20, 12'h020);
		addr(1'b0, 1'b0, 8'h80, 12'hF80);
		addr(1'b0, 1'b1, 8'h80, 12'h580);
		addr(1'b1, 1'b1, 8'h10, 12'h510);
		addr(1'b1, 1'b0, 8'h10, 12'h310);
		addr(1'b1, 1'b0, 8'h5F, 12'h35F);
		addr(1'b1, 1'b0, 8'h60, 12'hF60);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		ext_set_en = 1'b0;
		bank_select_reg = 4'h5;
		fsr2_base = 12'h300;
		file_data = 8'h01;
		next_two_word = 1'b0;
		table_latch = 8'h00;
		ptr_load = 1'b0;
		ptr_load_val = 21'h000000;
		hold_rd_idx = 3'h0;
		mismatches = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(table_pointer, PTR_RESET);
		rd_hold(3'h6, HOLD_RESET);
		sc_twrite();
		sc_skip();
		sc_addr();
		close_out();
	end
endmodule
`default_nettype wire
